// >>> shared/rcs_pkg.sv
// Constants, field layouts and types shared by the reset cause and state control block
`default_nettype none
package rcs_pkg;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int unsigned CLK_MHZ = 25;
	localparam int unsigned CLK_PERIOD_NS = 40;
	localparam int unsigned DRT_TIME_US = 18000;
	localparam int unsigned DRT_CYCLES = DRT_TIME_US * CLK_MHZ;
	// ------------------------------------------------------------
	// Bus geometry
	// ------------------------------------------------------------
	localparam int unsigned ADDR_W = 10;
	localparam int unsigned IDX_LSB = 2;
	localparam int unsigned IDX_W = 8;
	// ------------------------------------------------------------
	// Core file indices (byte address is four times the index)
	// ------------------------------------------------------------
	localparam logic [6:0] IDX_INDIRECT = 7'h00;
	localparam logic [6:0] IDX_TIMER = 7'h01;
	localparam logic [6:0] IDX_PC_LOW = 7'h02;
	localparam logic [6:0] IDX_FLAGS = 7'h03;
	localparam logic [6:0] IDX_POINTER = 7'h04;
	localparam logic [6:0] IDX_PORT_A = 7'h05;
	localparam logic [6:0] IDX_PORT_B = 7'h06;
	localparam logic [6:0] IDX_PORT_C = 7'h07;
	localparam logic [6:0] IDX_FILE_LO = 7'h08;
	localparam logic [6:0] IDX_FILE_TOP_LARGE = 7'h7F;
	localparam logic [6:0] IDX_FILE_TOP_SMALL = 7'h1F;
	// Control registers beyond the core file space
	localparam logic [7:0] REG_DIR_BASE = 8'h80;
	localparam logic [7:0] REG_OPTION = 8'h83;
	localparam logic [7:0] REG_WORK = 8'h84;
	localparam logic [7:0] REG_CAUSE_STAT = 8'h85;
	localparam logic [7:0] REG_CAUSE_MASK = 8'h86;
	localparam logic [7:0] REG_CORE_STATE = 8'h87;
	localparam int unsigned NUM_PORTS = 3;
	// ------------------------------------------------------------
	// Field positions and reset values
	// ------------------------------------------------------------
	localparam int unsigned FLAG_PAGE_HI = 7;
	localparam int unsigned FLAG_PAGE_LO = 5;
	localparam int unsigned FLAG_TIMEOUT = 4;
	localparam int unsigned FLAG_PWRDN = 3;
	localparam int unsigned FLAG_ARITH_HI = 2;
	localparam logic [2:0] PAGE_RESET = 3'h0;
	localparam logic [7:0] DIR_RESET = 8'hFF;
	localparam int unsigned OPTION_W = 6;
	localparam logic [OPTION_W-1:0] OPTION_RESET = 6'h3F;
	localparam logic PTR_TOP_LARGE = 1'h1;
	localparam logic [2:0] PTR_TOP_SMALL = 3'h7;
	// Timeout and power-down flag pairs {timeout, powerdown}
	localparam logic [1:0] TP_POWER_ON = 2'h3;
	localparam logic [1:0] TP_CLEAR_WAKE = 2'h2;
	localparam logic [1:0] TP_WATCH_RUN = 2'h1;
	localparam logic [1:0] TP_WATCH_WAKE = 2'h0;
	localparam logic [1:0] TP_SLEEP = 2'h2;
	localparam logic [1:0] TP_WATCH_CLEAR = 2'h3;
	// ------------------------------------------------------------
	// Types
	// ------------------------------------------------------------
	localparam int unsigned CAUSE_W = 5;
	typedef struct packed {
		logic watchdog_wake;
		logic watchdog_run;
		logic clear_wake;
		logic clear_run;
		logic power_on;
	} rcs_cause_s;
	typedef enum logic [1:0] {ST_HELD, ST_RUN, ST_SLEEP} rcs_state_e;
endpackage
`default_nettype wire

// >>> design/rcs_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`default_nettype none
`timescale 1ns/10ps
module rcs_pin_sync #(
	parameter int unsigned W = 2,
	parameter logic [W-1:0] RESET_VAL = '0
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic [W-1:0] d_in,
	output logic [W-1:0] q_out
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;

	// First stage feeds only the second
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			s1_r <= RESET_VAL;
			s2_r <= RESET_VAL;
			s3_r <= RESET_VAL;
		end else begin
			s1_r <= d_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
		end
	end

	// A change counts only once stages two and three agree
	for (genvar b = 0; b < W; b++) begin : g_bit
		always_ff @(posedge clk_in) begin
			if (rst_in) begin
				q_out[b] <= RESET_VAL[b];
			end else if (s2_r[b] == s3_r[b]) begin
				q_out[b] <= s3_r[b];
			end
		end
	end
endmodule // rcs_pin_sync
`default_nettype wire

// >>> design/rcs_release.sv
// Core reset stretcher: immediate assertion, clocked release after a hold count
`default_nettype none
`timescale 1ns/10ps
module rcs_release #(
	parameter int unsigned HOLD_CYCLES = 450000
) (
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic trigger_in,
	input wire logic hold_in,
	output logic core_rst_out
);
	localparam int unsigned CW = $clog2(HOLD_CYCLES + 1);
	logic busy_r;
	logic [CW-1:0] cnt_r;

	// Assertion is combinational so no cycle is lost on entry
	assign core_rst_out = rst_in | trigger_in | hold_in | busy_r;

	// Count restarts while a cause or the held pin persists
	always_ff @(posedge clk_in) begin
		if (rst_in || trigger_in || hold_in) begin
			busy_r <= 1'b1;
			cnt_r <= CW'(HOLD_CYCLES);
		end else if (busy_r) begin
			if (cnt_r == '0) begin
				busy_r <= 1'b0;
			end else begin
				cnt_r <= cnt_r - 1'b1;
			end
		end
	end
endmodule // rcs_release
`default_nettype wire

// >>> design/rcs_core_reset.sv
// Reset cause detection, cause flags and reset-state core registers behind APB
//
// Operation
// - Five causes enter reset: power-on, clear pin running, clear pin sleeping, watchdog running, watchdog sleeping.
// - A clear pin or watchdog wake from sleep performs a full reset, never a resume.
// - Registers without reset are unknown at power-on and keep their contents through every other reset.
// - All other registers take their reset state on power-on, clear pin and watchdog reset alike, except cause status and mask, reset on power-on only.
// - The timeout and powerdown flags in core flags bits four and three record the reset cause.
// - Flag pairs are power-on 1,1; clear running unchanged; clear wake 1,0; watchdog running 0,1; watchdog wake 0,0.
// - Power-on gives core flags 0001 1xxx; other resets clear page bits, set cause flags except on clear running, keep arithmetic bits.
// - Every reset loads the program counter low byte with all ones.
// - Every reset sets all port direction registers and the six option bits to ones.
// - Work register, indirect location, timer count, ports and files 08-7Fh are not touched by reset.
// - The pointer top bit reads one on the larger variant, the top three bits on the smaller one.
// - On the smaller variant address 07h is a general file with general file reset behaviour.
// - The timeout flag reads one after power-up, watchdog clear or sleep, zero only after a watchdog timeout.
// - The powerdown flag reads one after power-up or watchdog clear, zero after sleep.
// - Reset points the program counter at the reset vector and selects page zero.
//
// Design decision made here: the APB slave port.
`default_nettype none
`timescale 1ns/10ps
module rcs_core_reset #(
	parameter bit LARGE_VARIANT = 1'b1,
	parameter int unsigned PC_W = 11,
	parameter int unsigned DRT_CYCLES_P = rcs_pkg::DRT_CYCLES
) (
	input wire logic CLOCK_IN,
	input wire logic RST_IN,
	input wire logic PSEL_IN,
	input wire logic PENABLE_IN,
	input wire logic PWRITE_IN,
	input wire logic [rcs_pkg::ADDR_W-1:0] PADDR_IN,
	input wire logic [31:0] PWDATA_IN,
	output logic [31:0] PRDATA_OUT,
	output logic PREADY_OUT,
	output logic PSLVERR_OUT,
	input wire logic EXTERNAL_CLEAR_PIN_N_IN,
	input wire logic WATCHDOG_TIMEOUT_IN,
	input wire logic SLEEP_INSTR_IN,
	input wire logic WATCHDOG_CLEAR_INSTR_IN,
	output logic CORE_RESET_OUT,
	output logic SLEEPING_OUT,
	output logic [PC_W-1:0] PC_OUT,
	output logic [rcs_pkg::NUM_PORTS-1:0][7:0] PORT_LATCH_OUT,
	output logic [rcs_pkg::NUM_PORTS-1:0][7:0] PORT_OE_N_OUT,
	output logic [rcs_pkg::OPTION_W-1:0] OPTION_OUT,
	output logic IRQ_OUT
);
	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	localparam logic [6:0] FILE_TOP = LARGE_VARIANT ? rcs_pkg::IDX_FILE_TOP_LARGE : rcs_pkg::IDX_FILE_TOP_SMALL;
	localparam int unsigned FILE_DEPTH = 128;

	logic [1:0] pins_s;
	logic clear_n_s;
	logic watch_s;
	logic clear_prev_r;
	logic watch_prev_r;
	logic clear_evt;
	logic watch_evt;
	logic sleeping;
	logic any_cause;
	logic core_rst;
	rcs_pkg::rcs_cause_s cause;
	rcs_pkg::rcs_state_e state_r;
	logic [7:0] flags_r;
	logic [PC_W-1:0] pc_r;
	logic [6:0] ptr_r;
	logic [7:0] ptr_read;
	logic [6:0] ptr_addr;
	logic [rcs_pkg::NUM_PORTS-1:0][7:0] dir_r;
	logic [rcs_pkg::OPTION_W-1:0] option_r;
	logic [7:0] work_r;
	logic [7:0] timer_r;
	logic [rcs_pkg::NUM_PORTS-1:0][7:0] port_r;
	logic [7:0] gen_file_r [0:FILE_DEPTH-1];
	logic [rcs_pkg::CAUSE_W-1:0] cause_stat_r;
	logic [rcs_pkg::CAUSE_W-1:0] cause_mask_r;
	logic [31:0] prdata_r;
	logic [rcs_pkg::IDX_W-1:0] idx;
	logic in_file;
	logic mapped;
	logic wr_en;
	logic [6:0] target;
	logic target_is_file;
	logic [31:0] rd_val;

	// ------------------------------------------------------------
	// Pin synchronisers and cause detection
	// ------------------------------------------------------------
	// Pin idles high so power-up is not mistaken for a clear
	rcs_pin_sync #(
		.W(2),
		.RESET_VAL(2'h1)
	) u_pin_sync (
		.clk_in(CLOCK_IN),
		.rst_in(RST_IN),
		.d_in({WATCHDOG_TIMEOUT_IN, EXTERNAL_CLEAR_PIN_N_IN}),
		.q_out(pins_s)
	);
	assign clear_n_s = pins_s[0];
	assign watch_s = pins_s[1];

	// Edge history of the filtered pins
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			clear_prev_r <= 1'b1;
			watch_prev_r <= 1'b0;
		end else begin
			clear_prev_r <= clear_n_s;
			watch_prev_r <= watch_s;
		end
	end

	// Clear pin wins when both arrive together
	assign sleeping = (state_r == rcs_pkg::ST_SLEEP);
	assign clear_evt = clear_prev_r & ~clear_n_s;
	assign watch_evt = ~watch_prev_r & watch_s & ~clear_evt;
	always_comb begin
		cause.power_on = RST_IN;
		cause.clear_run = ~RST_IN & clear_evt & ~sleeping;
		cause.clear_wake = ~RST_IN & clear_evt & sleeping;
		cause.watchdog_run = ~RST_IN & watch_evt & ~sleeping;
		cause.watchdog_wake = ~RST_IN & watch_evt & sleeping;
	end
	assign any_cause = cause.clear_run | cause.clear_wake | cause.watchdog_run | cause.watchdog_wake;

	// ------------------------------------------------------------
	// Common core reset
	// ------------------------------------------------------------
	// One reset for every cause, held while the pin stays low
	rcs_release #(
		.HOLD_CYCLES(DRT_CYCLES_P)
	) u_release (
		.clk_in(CLOCK_IN),
		.rst_in(RST_IN),
		.trigger_in(any_cause),
		.hold_in(~clear_n_s),
		.core_rst_out(core_rst)
	);
	assign CORE_RESET_OUT = core_rst;

	// Sleep is left only through a reset, never by resuming
	always_ff @(posedge CLOCK_IN) begin
		if (core_rst) begin
			state_r <= rcs_pkg::ST_HELD;
		end else begin
			case (state_r)
				rcs_pkg::ST_HELD: state_r <= rcs_pkg::ST_RUN;
				rcs_pkg::ST_RUN: if (SLEEP_INSTR_IN) state_r <= rcs_pkg::ST_SLEEP;
				rcs_pkg::ST_SLEEP: state_r <= rcs_pkg::ST_SLEEP;
				default: state_r <= rcs_pkg::ST_HELD;
			endcase
		end
	end
	assign SLEEPING_OUT = sleeping;

	// ------------------------------------------------------------
	// APB decode
	// ------------------------------------------------------------
	assign idx = PADDR_IN[rcs_pkg::IDX_LSB +: rcs_pkg::IDX_W];
	assign in_file = ~idx[7] & (idx[6:0] <= FILE_TOP);
	assign mapped = in_file | (idx >= rcs_pkg::REG_DIR_BASE && idx <= rcs_pkg::REG_CORE_STATE);
	assign wr_en = PSEL_IN & PENABLE_IN & PWRITE_IN & mapped;
	// Pointer reaches every file on the larger variant, 00h-1Fh on the smaller
	assign ptr_addr = LARGE_VARIANT ? ptr_r : {2'h0, ptr_r[4:0]};
	assign target = (idx[6:0] == rcs_pkg::IDX_INDIRECT) ? ptr_addr : idx[6:0];
	assign target_is_file = (target >= rcs_pkg::IDX_FILE_LO && target <= FILE_TOP) ||
		(!LARGE_VARIANT && target == rcs_pkg::IDX_PORT_C);
	// Unimplemented pointer bits always read as one
	assign ptr_read = LARGE_VARIANT ? {rcs_pkg::PTR_TOP_LARGE, ptr_r} :
		{rcs_pkg::PTR_TOP_SMALL, ptr_r[4:0]};

	// ------------------------------------------------------------
	// Core flags
	// ------------------------------------------------------------
	// Cause flags are read-only to software; arithmetic bits survive non power-on resets
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			flags_r[rcs_pkg::FLAG_PAGE_HI:rcs_pkg::FLAG_PAGE_LO] <= rcs_pkg::PAGE_RESET;
			flags_r[rcs_pkg::FLAG_TIMEOUT:rcs_pkg::FLAG_PWRDN] <= rcs_pkg::TP_POWER_ON;
		end else if (any_cause) begin
			flags_r[rcs_pkg::FLAG_PAGE_HI:rcs_pkg::FLAG_PAGE_LO] <= rcs_pkg::PAGE_RESET;
			if (cause.clear_wake) begin
				flags_r[rcs_pkg::FLAG_TIMEOUT:rcs_pkg::FLAG_PWRDN] <= rcs_pkg::TP_CLEAR_WAKE;
			end else if (cause.watchdog_run) begin
				flags_r[rcs_pkg::FLAG_TIMEOUT:rcs_pkg::FLAG_PWRDN] <= rcs_pkg::TP_WATCH_RUN;
			end else if (cause.watchdog_wake) begin
				flags_r[rcs_pkg::FLAG_TIMEOUT:rcs_pkg::FLAG_PWRDN] <= rcs_pkg::TP_WATCH_WAKE;
			end
		end else if (core_rst) begin
			flags_r[rcs_pkg::FLAG_PAGE_HI:rcs_pkg::FLAG_PAGE_LO] <= rcs_pkg::PAGE_RESET;
		end else begin
			if (state_r == rcs_pkg::ST_RUN && SLEEP_INSTR_IN) begin
				flags_r[rcs_pkg::FLAG_TIMEOUT:rcs_pkg::FLAG_PWRDN] <= rcs_pkg::TP_SLEEP;
			end else if (state_r == rcs_pkg::ST_RUN && WATCHDOG_CLEAR_INSTR_IN) begin
				flags_r[rcs_pkg::FLAG_TIMEOUT:rcs_pkg::FLAG_PWRDN] <= rcs_pkg::TP_WATCH_CLEAR;
			end
			if (wr_en && in_file && target == rcs_pkg::IDX_FLAGS) begin
				flags_r[rcs_pkg::FLAG_PAGE_HI:rcs_pkg::FLAG_PAGE_LO] <=
					PWDATA_IN[rcs_pkg::FLAG_PAGE_HI:rcs_pkg::FLAG_PAGE_LO];
				flags_r[rcs_pkg::FLAG_ARITH_HI:0] <= PWDATA_IN[rcs_pkg::FLAG_ARITH_HI:0];
			end
		end
	end

	// ------------------------------------------------------------
	// Reset-state registers
	// ------------------------------------------------------------
	// Program counter lands on the reset vector
	always_ff @(posedge CLOCK_IN) begin
		if (core_rst) begin
			pc_r <= '1;
		end else if (wr_en && in_file && target == rcs_pkg::IDX_PC_LOW) begin
			pc_r[7:0] <= PWDATA_IN[7:0];
		end
	end
	assign PC_OUT = pc_r;

	// Every pin reverts to input on any reset
	for (genvar p = 0; p < rcs_pkg::NUM_PORTS; p++) begin : g_dir
		always_ff @(posedge CLOCK_IN) begin
			if (core_rst) begin
				dir_r[p] <= rcs_pkg::DIR_RESET;
			end else if (wr_en && idx == rcs_pkg::REG_DIR_BASE + 8'(p)) begin
				dir_r[p] <= PWDATA_IN[7:0];
			end
		end
		// Active-low enable equals the direction bit: one means input
		assign PORT_OE_N_OUT[p] = dir_r[p];
	end

	// Option register
	always_ff @(posedge CLOCK_IN) begin
		if (core_rst) begin
			option_r <= rcs_pkg::OPTION_RESET;
		end else if (wr_en && idx == rcs_pkg::REG_OPTION) begin
			option_r <= PWDATA_IN[rcs_pkg::OPTION_W-1:0];
		end
	end
	assign OPTION_OUT = option_r;

	// ------------------------------------------------------------
	// Registers without reset
	// ------------------------------------------------------------
	// No reset term: contents are unknown at power-up and survive other resets
	always_ff @(posedge CLOCK_IN) begin
		if (wr_en && idx == rcs_pkg::REG_WORK) work_r <= PWDATA_IN[7:0];
		if (wr_en && in_file && target == rcs_pkg::IDX_TIMER) timer_r <= PWDATA_IN[7:0];
		if (wr_en && in_file && target == rcs_pkg::IDX_POINTER) ptr_r <= PWDATA_IN[6:0];
		if (wr_en && in_file && target == rcs_pkg::IDX_PORT_A) port_r[0] <= PWDATA_IN[7:0];
		if (wr_en && in_file && target == rcs_pkg::IDX_PORT_B) port_r[1] <= PWDATA_IN[7:0];
		if (wr_en && in_file && LARGE_VARIANT && target == rcs_pkg::IDX_PORT_C) port_r[2] <= PWDATA_IN[7:0];
		if (wr_en && in_file && target_is_file) gen_file_r[target] <= PWDATA_IN[7:0];
	end
	assign PORT_LATCH_OUT = port_r;

	// ------------------------------------------------------------
	// Cause status and interrupt
	// ------------------------------------------------------------
	// Sticky cause bits, write one to clear; a new cause wins over the clear
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			cause_stat_r <= rcs_pkg::CAUSE_W'(1);
		end else begin
			cause_stat_r <= (cause_stat_r & ~((wr_en && idx == rcs_pkg::REG_CAUSE_STAT) ?
				PWDATA_IN[rcs_pkg::CAUSE_W-1:0] : '0)) | cause;
		end
	end

	// Mask enables each cause onto the interrupt
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			cause_mask_r <= '0;
		end else if (wr_en && idx == rcs_pkg::REG_CAUSE_MASK) begin
			cause_mask_r <= PWDATA_IN[rcs_pkg::CAUSE_W-1:0];
		end
	end
	assign IRQ_OUT = |(cause_stat_r & cause_mask_r);

	// ------------------------------------------------------------
	// APB read path
	// ------------------------------------------------------------
	// Read value chosen from the resolved target
	always_comb begin
		rd_val = '0;
		if (in_file) begin
			if (idx[6:0] == rcs_pkg::IDX_INDIRECT && ptr_addr == rcs_pkg::IDX_INDIRECT) rd_val = '0;
			else if (target_is_file) rd_val[7:0] = gen_file_r[target];
			else begin
				case (target)
					rcs_pkg::IDX_TIMER: rd_val[7:0] = timer_r;
					rcs_pkg::IDX_PC_LOW: rd_val[7:0] = pc_r[7:0];
					rcs_pkg::IDX_FLAGS: rd_val[7:0] = flags_r;
					rcs_pkg::IDX_POINTER: rd_val[7:0] = ptr_read;
					rcs_pkg::IDX_PORT_A: rd_val[7:0] = port_r[0];
					rcs_pkg::IDX_PORT_B: rd_val[7:0] = port_r[1];
					rcs_pkg::IDX_PORT_C: rd_val[7:0] = port_r[2];
					default: rd_val = '0;
				endcase
			end
		end else begin
			case (idx)
				rcs_pkg::REG_DIR_BASE: rd_val[7:0] = dir_r[0];
				rcs_pkg::REG_DIR_BASE + 8'h01: rd_val[7:0] = dir_r[1];
				rcs_pkg::REG_DIR_BASE + 8'h02: rd_val[7:0] = dir_r[2];
				rcs_pkg::REG_OPTION: rd_val[rcs_pkg::OPTION_W-1:0] = option_r;
				rcs_pkg::REG_WORK: rd_val[7:0] = work_r;
				rcs_pkg::REG_CAUSE_STAT: rd_val[rcs_pkg::CAUSE_W-1:0] = cause_stat_r;
				rcs_pkg::REG_CAUSE_MASK: rd_val[rcs_pkg::CAUSE_W-1:0] = cause_mask_r;
				rcs_pkg::REG_CORE_STATE: rd_val[2:0] = {sleeping, state_r == rcs_pkg::ST_RUN, core_rst};
				default: rd_val = '0;
			endcase
		end
	end

	// Read data captured in the setup cycle, so the access phase needs no wait
	always_ff @(posedge CLOCK_IN) begin
		if (RST_IN) begin
			prdata_r <= '0;
		end else if (PSEL_IN && !PENABLE_IN) begin
			prdata_r <= rd_val;
		end
	end
	assign PRDATA_OUT = prdata_r;
	assign PREADY_OUT = 1'b1;
	assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~mapped;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge CLOCK_IN); endclocking
	default disable iff (RST_IN);

	pc_vector_a: assert property (core_rst |=> pc_r == {PC_W{1'b1}})
		else $error("pc not at reset vector after reset");
	dir_inputs_a: assert property (core_rst |=> dir_r == {rcs_pkg::NUM_PORTS{rcs_pkg::DIR_RESET}})
		else $error("direction not all inputs after reset");
	option_ones_a: assert property (core_rst |=> OPTION_OUT == rcs_pkg::OPTION_RESET)
		else $error("option not all ones after reset");
	clear_wake_flags_a: assert property (cause.clear_wake |=> flags_r[4:3] == 2'h2 && CORE_RESET_OUT)
		else $error("clear wake flags wrong");
	watch_run_flags_a: assert property (cause.watchdog_run |=> flags_r[4:3] == 2'h1)
		else $error("watchdog run flags wrong");
	watch_wake_flags_a: assert property (cause.watchdog_wake |=> flags_r[4:3] == 2'h0 && !SLEEPING_OUT)
		else $error("watchdog wake flags wrong");
	clear_run_keep_a: assert property (cause.clear_run |=> $stable(flags_r[4:3]))
		else $error("clear run changed cause flags");
	page_zero_a: assert property (core_rst |=> flags_r[7:5] == 3'h0)
		else $error("page bits not cleared by reset");
	wake_full_reset_a: assert property (SLEEPING_OUT && any_cause |-> CORE_RESET_OUT ##1 state_r == rcs_pkg::ST_HELD)
		else $error("wake did not reset core");
	sleep_flags_a: assert property (state_r == rcs_pkg::ST_RUN && SLEEP_INSTR_IN && !core_rst
		|=> SLEEPING_OUT && flags_r[4:3] == 2'h2)
		else $error("sleep did not set flags");
	work_kept_a: assert property (core_rst && !wr_en && $past(wr_en && idx == rcs_pkg::REG_WORK) |=> $stable(work_r))
		else $error("work register changed by reset");
	release_edge_a: assert property ($fell(CORE_RESET_OUT) |-> state_r == rcs_pkg::ST_HELD ##1 state_r == rcs_pkg::ST_RUN)
		else $error("core did not leave reset on one edge");

	por_cov_c: cover property ($fell(RST_IN));
	clear_wake_c: cover property (cause.clear_wake);
	watch_run_c: cover property (cause.watchdog_run);
	watch_wake_c: cover property (cause.watchdog_wake);
endmodule // rcs_core_reset
`default_nettype wire

// >>> verif/rcs_far_side.sv
// Far-side model: external clear pin driver and watchdog timeout source
`timescale 1ns/10ps
`default_nettype none
module rcs_far_side (
	input wire logic clk_in,
	output logic clear_n_out,
	output logic wdt_out
);
	// Idle levels: pin pulled high, no timeout
	initial begin
		clear_n_out = 1'b1;
		wdt_out = 1'b0;
	end
	// One event, held past the pin filter delay so it is not lost
	task automatic fire(input bit is_clear, input int n);
		@(posedge clk_in);
		if (is_clear) begin
			clear_n_out <= 1'b0;
		end else begin
			wdt_out <= 1'b1;
		end
		repeat (n) @(posedge clk_in);
		clear_n_out <= 1'b1;
		wdt_out <= 1'b0;
	endtask
endmodule // rcs_far_side
`default_nettype wire

// >>> verif/rcs_core_reset_tb.sv
// Self-checking bench for the reset cause and state control block
`timescale 1ns/10ps
`default_nettype none
module rcs_core_reset_tb;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic pen = 1'b0;
	logic pwr = 1'b0;
	logic [9:0] paddr = 10'h000;
	logic [31:0] pwdata = 32'h0;
	logic slp = 1'b0;
	logic wclr = 1'b0;
	wire logic clr_n;
	wire logic wdt;
	logic [31:0] prdata;
	logic pready, pslverr, core_rst, sleeping, irq;
	logic [10:0] pc;
	logic [2:0][7:0] oe_n, latch;
	logic [5:0] opt;
	logic [64:0] note_q[$];
	logic [64:0] note;
	logic [7:0] fval;
	int n_mismatch = 0;
	int checks_done = 0;
	int seed = 32'h1F1775D7;
	always #20 clk = ~clk;
	rcs_core_reset #(.DRT_CYCLES_P(8)) u_dut (.CLOCK_IN(clk), .RST_IN(rst), .PSEL_IN(psel),
		.PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata),
		.PREADY_OUT(pready), .PSLVERR_OUT(pslverr), .EXTERNAL_CLEAR_PIN_N_IN(clr_n),
		.WATCHDOG_TIMEOUT_IN(wdt), .SLEEP_INSTR_IN(slp), .WATCHDOG_CLEAR_INSTR_IN(wclr),
		.CORE_RESET_OUT(core_rst), .SLEEPING_OUT(sleeping), .PC_OUT(pc), .PORT_LATCH_OUT(latch),
		.PORT_OE_N_OUT(oe_n), .OPTION_OUT(opt), .IRQ_OUT(irq));
	rcs_far_side u_far (.clk_in(clk), .clear_n_out(clr_n), .wdt_out(wdt));
	// ---------------------------------------------
	// Checking and closing
	// ---------------------------------------------
	task automatic summarize();
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	// Read results taken at the completing edge, against the oldest note
	always @(posedge clk) begin
		if (psel === 1'b1 && pen === 1'b1 && pwr === 1'b0 && pready === 1'b1) begin
			note = note_q.pop_front();
			cmp("prdata", note[31:0], prdata & note[63:32]);
			cmp("pslverr", {31'h0, note[64]}, {31'h0, pslverr});
		end
	end
	// ---------------------------------------------
	// Drivers
	// ---------------------------------------------
	// APB transfer; a read notes {error, mask, expected} first
	task automatic apb(input logic wr, input logic [9:0] a, input logic [31:0] d, input logic [31:0] m,
		input logic e);
		int t;
		if (!wr) note_q.push_back({e, m, d});
		psel <= 1'b1;
		pwr <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		t = 0;
		do begin
			@(posedge clk);
			t++;
		end while (pready !== 1'b1 && t < 50);
		if (pready !== 1'b1) begin
			n_mismatch++;
			summarize();
		end
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk); // Idle edge so a following call never re-drives psel in the same step
	endtask
	task automatic flags(input logic [1:0] tp);
		apb(1'b0, 10'h00C, {27'h0, tp, 3'h0}, 32'hFFFFFFF8, 1'b0);
	endtask
	task automatic pulse(input bit is_sleep);
		if (is_sleep) slp <= 1'b1;
		else wclr <= 1'b1;
		@(posedge clk);
		slp <= 1'b0;
		wclr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic late(input string what, input logic [31:0] exp);
		@(negedge clk);
		cmp(what, exp, what == "irq" ? {31'h0, irq} : what == "sleeping" ? {31'h0, sleeping} : {26'h0, opt});
		@(posedge clk);
	endtask
	// Whole reset: forced state checked while core held, then wait for release
	task automatic ride_reset();
		int t;
		t = 0;
		while (core_rst !== 1'b1 && t < 100) begin
			@(negedge clk);
			t++;
		end
		if (core_rst !== 1'b1) begin
			n_mismatch++;
			summarize();
		end
		repeat (2) @(negedge clk);
		cmp("pc", 32'h7FF, {21'h0, pc});
		cmp("dir", 32'hFFFFFF, {8'h0, oe_n});
		cmp("option", 32'h3F, {26'h0, opt});
		while (core_rst !== 1'b0 && t < 200) begin
			@(negedge clk);
			t++;
		end
		if (core_rst !== 1'b0) begin
			n_mismatch++;
			summarize();
		end
		repeat (2) @(posedge clk);
	endtask
	// ---------------------------------------------
	// Main sequence
	// ---------------------------------------------
	initial begin
		repeat (16) @(posedge clk);
		rst <= 1'b0;
		ride_reset();
		flags(2'h3);
		apb(1'b0, 10'h010, 32'h80, 32'h80, 1'b0);
		fval = 8'($random(seed));
		apb(1'b1, 10'h040, {24'h0, fval}, 32'h0, 1'b0);
		apb(1'b1, 10'h018, {24'h0, fval}, 32'h0, 1'b0);
		apb(1'b1, 10'h010, 32'h10, 32'h0, 1'b0);
		apb(1'b0, 10'h000, {24'h0, fval}, 32'hFF, 1'b0);
		apb(1'b1, 10'h20C, 32'h0, 32'h0, 1'b0);
		apb(1'b1, 10'h218, 32'h1F, 32'h0, 1'b0);
		apb(1'b0, 10'h214, 32'h1, 32'hFFFFFFFF, 1'b0);
		late("option", 32'h0);
		late("irq", 32'h1);
		apb(1'b1, 10'h214, 32'h1F, 32'h0, 1'b0);
		late("irq", 32'h0);
		apb(1'b0, 10'h220, 32'h0, 32'hFFFFFFFF, 1'b1);
		u_far.fire(1'b0, 8);
		apb(1'b1, 10'h210, {24'h0, fval}, 32'h0, 1'b0);
		ride_reset();
		flags(2'h1);
		apb(1'b0, 10'h040, {24'h0, fval}, 32'hFFFFFFFF, 1'b0);
		apb(1'b0, 10'h210, {24'h0, fval}, 32'hFFFFFFFF, 1'b0);
		apb(1'b0, 10'h010, 32'h90, 32'hFF, 1'b0);
		cmp("latch", {24'h0, fval}, {24'h0, latch[1]});
		pulse(1'b0);
		flags(2'h3);
		pulse(1'b1);
		late("sleeping", 32'h1);
		flags(2'h2);
		u_far.fire(1'b1, 8);
		ride_reset();
		late("sleeping", 32'h0);
		flags(2'h2);
		pulse(1'b1);
		u_far.fire(1'b0, 8);
		ride_reset();
		flags(2'h0);
		u_far.fire(1'b1, 8);
		ride_reset();
		flags(2'h0);
		apb(1'b0, 10'h214, 32'h1E, 32'hFFFFFFFF, 1'b0);
		late("irq", 32'h1);
		summarize();
	end
endmodule // rcs_core_reset_tb
`default_nettype wire
